// file: shared/rco_defs.svh
// register offsets, field positions, reset values and sizes for the reference clock output
`ifndef RCO_DEFS_SVH
`define RCO_DEFS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define RCO_ADDR_W 4
`define RCO_DATA_W 8
`define RCO_ADDR_CONTROL 4'h0
`define RCO_ADDR_SOURCE 4'h1
`define RCO_ADDR_STATUS 4'h2

// ------------------------------------------------------------
// control, source and status register fields
// ------------------------------------------------------------
`define RCO_CTL_EN_BIT 7
`define RCO_CTL_DUTY_HI 4
`define RCO_CTL_DUTY_LO 3
`define RCO_CTL_DIV_HI 2
`define RCO_CTL_DIV_LO 0
`define RCO_SRC_HI 1
`define RCO_SRC_LO 0
`define RCO_STAT_PIN_BIT 0
`define RCO_STAT_RUN_BIT 1

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define RCO_DUTY_RESET 2'h2
`define RCO_DUTY_OFF 2'h0
`define RCO_DUTY_HALF 2'h2
`define RCO_DIV_RESET 3'h0
`define RCO_DIV_UNDIVIDED 3'h0
`define RCO_DIV_BY2 3'h1
`define RCO_SRC_RESET 2'h0
`define RCO_SRC_SYSTEM 2'h0
`define RCO_CNT_W 8
`define RCO_CNT_FULL 8'hFF
`define RCO_CNT_ONE 8'h01
`define RCO_DIV_MAX 3'h7

`endif

// file: shared/rco_pkg.sv
// types shared by the reference clock output design
package rco_pkg;

   typedef struct packed {
      logic enable;
      logic [1:0] duty;
      logic [2:0] div;
   } rco_ctrl_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rco_bus_req_type;

   typedef enum logic [1:0] {
      RCO_OFF,
      RCO_WAIT,
      RCO_RUN
   } rco_state_type;

endpackage

// file: verilog/rco_edge_tick.sv
// synchroniser and both-edge detector for one external clock source
`timescale 1ns/1ns
`include "rco_defs.svh"
module rco_edge_tick (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous source level
   input wire logic src_async,
   // synchronised level and edge pulse
   output logic src_level,
   output logic src_edge
);
   logic meta_reg, meta_next;
   logic sync_reg, sync_next;
   logic last_reg, last_next;

   always_comb begin
      meta_next = src_async;
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   // each edge of the source is one half period of the base clock
   assign src_level = sync_reg;
   assign src_edge = sync_reg ^ last_reg;
endmodule // rco_edge_tick

// file: verilog/rco_refout.sv
// reference clock output: source select, power-of-two divider, duty shaping
`timescale 1ns/1ns
`include "rco_defs.svh"

// What this block does
// - A source-select setting picks the clock that feeds the divider.
// - Setting the enable starts the output with a full first pulse and no runt.
// - Clearing the enable drives the output low at once, mid-period or not.
// - A three-bit divider field divides the base clock by 1, 2, 4, 8, 16, 32, 64 or 128.
// - A two-bit duty field makes the high time 0%, 25%, 50% or 75% of every divided period.
// - With ratio 1 the duty field is ignored and the output follows the base clock.
// - Reset loads the duty field with its upper bit set, so the default duty is 50%.
// - The divider may change while enabled and may glitch; software should change it disabled.
// - The duty may change while enabled and may glitch; software should change it disabled.
// - While the device sleeps the output holds the level it had on entry.
module rco_refout
   import rco_pkg::*;
#(
   parameter int NUM_EXT = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [`RCO_ADDR_W-1:0] addr,
   input wire logic [`RCO_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [`RCO_DATA_W-1:0] rdata,
   // external clock sources and power state
   input wire logic [NUM_EXT-1:0] ext_clk,
   input wire logic sleep,
   // reference clock pin
   output logic reference_clock_pin
);

   // ------------------------------------------------------------
   // source selection
   // ------------------------------------------------------------
   logic [NUM_EXT-1:0] ext_edge;
   logic [NUM_EXT:0] tick_vec;
   logic tick;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_EXT; gi++) begin : g_src
         rco_edge_tick u_tick (
            .clk(clk),
            .rst_n(rst_n),
            .src_async(ext_clk[gi]),
            .src_level(),
            .src_edge(ext_edge[gi])
         );
      end
   endgenerate

   // the system clock base toggles every cycle, so it ticks every cycle
   assign tick_vec = {ext_edge, 1'b1};

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   rco_ctrl_type ctrl_reg, ctrl_next;
   logic [1:0] refout_source_sel_reg, refout_source_sel_next;
   logic [`RCO_DATA_W-1:0] rdata_reg, rdata_next;
   rco_state_type state_reg, state_next;
   logic [`RCO_CNT_W-1:0] cnt_reg, cnt_next;
   logic pin_reg, pin_next;

   logic [`RCO_CNT_W-1:0] period_mask;
   logic [`RCO_CNT_W-1:0] high_ticks;
   logic [`RCO_CNT_W-1:0] cnt_step;

   // out-of-range source codes fall back to no ticks rather than wrapping
   assign tick = (refout_source_sel_reg <= 2'(NUM_EXT)) ?
                 tick_vec[refout_source_sel_reg] : 1'b0;

   always_comb begin
      ctrl_next = ctrl_reg;
      refout_source_sel_next = refout_source_sel_reg;
      rdata_next = '0;
      if (wr) begin
         case (addr)
            `RCO_ADDR_CONTROL: begin
               // divider and duty are taken as written even while running
               ctrl_next.enable = wdata[`RCO_CTL_EN_BIT];
               ctrl_next.duty = wdata[`RCO_CTL_DUTY_HI:`RCO_CTL_DUTY_LO];
               ctrl_next.div = wdata[`RCO_CTL_DIV_HI:`RCO_CTL_DIV_LO];
            end
            `RCO_ADDR_SOURCE: begin
               refout_source_sel_next = wdata[`RCO_SRC_HI:`RCO_SRC_LO];
            end
            default: begin
            end
         endcase
      end
      if (rd) begin
         case (addr)
            `RCO_ADDR_CONTROL: begin
               rdata_next[`RCO_CTL_EN_BIT] = ctrl_reg.enable;
               rdata_next[`RCO_CTL_DUTY_HI:`RCO_CTL_DUTY_LO] = ctrl_reg.duty;
               rdata_next[`RCO_CTL_DIV_HI:`RCO_CTL_DIV_LO] = ctrl_reg.div;
            end
            `RCO_ADDR_SOURCE: begin
               rdata_next[`RCO_SRC_HI:`RCO_SRC_LO] = refout_source_sel_reg;
            end
            `RCO_ADDR_STATUS: begin
               rdata_next[`RCO_STAT_PIN_BIT] = pin_reg;
               rdata_next[`RCO_STAT_RUN_BIT] = (state_reg == RCO_RUN);
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg.enable <= 1'b0;
         ctrl_reg.duty <= `RCO_DUTY_RESET;
         ctrl_reg.div <= `RCO_DIV_RESET;
         refout_source_sel_reg <= `RCO_SRC_RESET;
         rdata_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         refout_source_sel_reg <= refout_source_sel_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;

   // ------------------------------------------------------------
   // divider and duty shaping
   // ------------------------------------------------------------
   // a divided period of 2^n base periods spans 2^(n+1) ticks
   assign period_mask = `RCO_CNT_FULL >> (`RCO_DIV_MAX - ctrl_reg.div);
   // high time is duty quarters of the period; code 0 gives none
   assign high_ticks = (ctrl_reg.div == `RCO_DIV_UNDIVIDED) ? '0 :
                       (`RCO_CNT_W'(ctrl_reg.duty) << (ctrl_reg.div - 3'h1));
   assign cnt_step = (cnt_reg == period_mask) ? '0 : cnt_reg + `RCO_CNT_ONE;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      pin_next = pin_reg;
      if (sleep) begin
         // system clock is gone in sleep; everything holds
         state_next = state_reg;
      end else if (!ctrl_reg.enable) begin
         state_next = RCO_OFF;
         cnt_next = '0;
         pin_next = 1'b0;
      end else begin
         case (state_reg)
            RCO_OFF: begin
               state_next = RCO_WAIT;
               cnt_next = '0;
               pin_next = 1'b0;
            end
            RCO_WAIT: begin
               // start on a base edge so the first pulse is full width
               if (tick) begin
                  state_next = RCO_RUN;
                  cnt_next = '0;
                  pin_next = (ctrl_reg.div == `RCO_DIV_UNDIVIDED) ? 1'b1 :
                             (high_ticks != '0);
               end
            end
            RCO_RUN: begin
               if (tick) begin
                  cnt_next = cnt_step;
                  if (ctrl_reg.div == `RCO_DIV_UNDIVIDED) begin
                     pin_next = ~pin_reg;
                  end else begin
                     pin_next = (cnt_step < high_ticks);
                  end
               end
            end
            default: begin
               state_next = RCO_OFF;
               cnt_next = '0;
               pin_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= RCO_OFF;
         cnt_reg <= '0;
         pin_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pin_reg <= pin_next;
      end
   end

   assign reference_clock_pin = pin_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence seq_awake_on;
      !sleep && ctrl_reg.enable;
   endsequence

   sequence seq_run_tick;
      seq_awake_on and (state_reg == RCO_RUN && tick);
   endsequence

   sequence seq_start;
      seq_awake_on and (state_reg == RCO_WAIT && tick);
   endsequence

   a_disable_stops_pin: assert property (@(posedge clk) disable iff (!rst_n)
      (!sleep && !ctrl_reg.enable) |=> !reference_clock_pin && state_reg == RCO_OFF)
      else $error("output still active one cycle after disable");

   a_sleep_holds_pin: assert property (@(posedge clk) disable iff (!rst_n)
      sleep |=> $stable(reference_clock_pin) && $stable(cnt_reg))
      else $error("output changed during sleep");

   a_duty_reset_half: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> ctrl_reg.duty == `RCO_DUTY_RESET && !ctrl_reg.enable)
      else $error("duty field not at half duty after reset");

   a_start_full_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      seq_start |=> state_reg == RCO_RUN && cnt_reg == '0)
      else $error("start did not align counter to zero");

   a_system_source_starts: assert property (@(posedge clk) disable iff (!rst_n)
      (refout_source_sel_reg == `RCO_SRC_SYSTEM && state_reg == RCO_OFF) and seq_awake_on
      |=> ##1 state_reg == RCO_RUN)
      else $error("system clock source did not start within two cycles");

   a_undivided_follows: assert property (@(posedge clk) disable iff (!rst_n)
      seq_run_tick and (ctrl_reg.div == `RCO_DIV_UNDIVIDED) |=>
      reference_clock_pin != $past(reference_clock_pin))
      else $error("undivided output did not follow base edge");

   a_counter_wraps: assert property (@(posedge clk) disable iff (!rst_n)
      seq_run_tick and (cnt_reg == period_mask) |=> cnt_reg == '0)
      else $error("divider counter did not wrap at period end");

   a_half_duty_low: assert property (@(posedge clk) disable iff (!rst_n)
      seq_run_tick and (ctrl_reg.div == `RCO_DIV_BY2 && ctrl_reg.duty == `RCO_DUTY_HALF &&
      cnt_reg == `RCO_CNT_ONE) |=> !reference_clock_pin && cnt_reg == 8'h02)
      else $error("half duty divide by two not low in second half");

   a_duty_zero_low: assert property (@(posedge clk) disable iff (!rst_n)
      seq_awake_on and (ctrl_reg.duty == `RCO_DUTY_OFF &&
      ctrl_reg.div != `RCO_DIV_UNDIVIDED && !reference_clock_pin) |=> !reference_clock_pin)
      else $error("duty code zero produced a high output");

   a_read_latency: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && addr == `RCO_ADDR_CONTROL) |=>
      rdata[`RCO_CTL_DIV_HI:`RCO_CTL_DIV_LO] == $past(ctrl_reg.div))
      else $error("control read data wrong in cycle after read strobe");

endmodule // rco_refout

// file: bench/rco_ext_osc.sv
// free-running external clock sources feeding the reference clock output
`timescale 1ns/1ns
module rco_ext_osc #(
   parameter int NUM_EXT = 2,
   parameter int HALF_NS = 60
) (
   // clock sources, source i has half period HALF_NS*(i+1)
   output logic [NUM_EXT-1:0] ext_clk
);
   // ------------------------------------------------------------
   // oscillators
   // ------------------------------------------------------------
   // 7 ns offset keeps every edge away from the system clock edge,
   // so the synchroniser delay is the same on every run
   for (genvar i = 0; i < NUM_EXT; i++) begin : g_osc
      initial begin
         ext_clk[i] = 1'h0;
         #7;
         forever begin
            #(HALF_NS * (i + 1));
            ext_clk[i] = ~ext_clk[i];
         end
      end
   end
endmodule // rco_ext_osc

// file: bench/testbench.sv
// self-checking testbench for the reference clock output
`timescale 1ns/1ns
`include "rco_defs.svh"
module testbench;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic sleep = 1'h0;
   logic [7:0] rdata;
   logic [1:0] ext_clk;
   logic reference_clock_pin;
   int n_errors = 0;
   int tests_run = 0;
   int hi;
   int lo;
   logic [7:0] rv;

   always #10 clk = ~clk;

   rco_ext_osc #(.NUM_EXT(2)) osc (.ext_clk(ext_clk));

   rco_refout #(.NUM_EXT(2)) dut (
      .clk(clk),
      .rst_n(rst_n),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .ext_clk(ext_clk),
      .sleep(sleep),
      .reference_clock_pin(reference_clock_pin)
   );

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic results();
      if (n_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      d = rdata;
   endtask

   // counts samples until the pin shows lvl; gives up after bound
   task automatic wait_pin(input logic lvl, input int bound, output int n);
      n = 0;
      while (reference_clock_pin !== lvl) begin
         @(posedge clk);
         #1;
         n++;
         if (n > bound) begin
            n_errors++;
            $display("[ERR] pin wait expected %0h seen timeout", lvl);
            results();
         end
      end
   endtask

   task automatic count_hi(input int cycles, output int n);
      n = 0;
      repeat (cycles) begin
         @(posedge clk);
         #1;
         check("pin known", 16'($isunknown(reference_clock_pin)), 16'h0000);
         n += int'(reference_clock_pin === 1'h1);
      end
   endtask

   // first pulse after enable must already be full width
   task automatic measure(output int h, output int l);
      int w;
      #1;
      wait_pin(1'h1, 600, w);
      wait_pin(1'h0, 300, h);
      wait_pin(1'h1, 300, l);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      #1;
      check("pin after reset", 16'(reference_clock_pin), 16'h0000);
      reg_rd(`RCO_ADDR_CONTROL, rv);
      check("control reset", 16'(rv), 16'({3'h0, `RCO_DUTY_RESET, `RCO_DIV_RESET}));
      reg_rd(`RCO_ADDR_SOURCE, rv);
      check("source reset", 16'(rv), 16'h0000);
      reg_rd(4'hF, rv);
      check("unmapped read", 16'(rv), 16'h0000);
      // software changes fields only while disabled
      for (int dv = 0; dv < 8; dv++) begin
         for (int dc = 0; dc < 4; dc++) begin
            reg_wr(`RCO_ADDR_CONTROL, {3'h0, dc[1:0], dv[2:0]});
            reg_wr(`RCO_ADDR_CONTROL, {3'h4, dc[1:0], dv[2:0]});
            if (dv != 0 && dc == 0) begin
               count_hi(1 << (dv + 2), hi);
               check("duty off high", 16'(hi), 16'h0000);
            end else begin
               measure(hi, lo);
               check("high time", 16'(hi), 16'((dv == 0) ? 1 : dc * (1 << (dv - 1))));
               check("period", 16'(hi + lo), 16'(1 << (dv + 1)));
            end
         end
      end
      // disable two cycles after a long high phase starts
      reg_wr(`RCO_ADDR_CONTROL, 8'h1F);
      reg_wr(`RCO_ADDR_CONTROL, 8'h9F);
      measure(hi, lo);
      reg_wr(`RCO_ADDR_CONTROL, 8'h1F);
      @(posedge clk);
      #1;
      check("pin after disable", 16'(reference_clock_pin), 16'h0000);
      count_hi(300, hi);
      check("disabled high", 16'(hi), 16'h0000);
      // sleep entered while the pin is high
      reg_wr(`RCO_ADDR_CONTROL, 8'h9B);
      measure(hi, lo);
      @(posedge clk);
      sleep <= 1'h1;
      count_hi(40, hi);
      check("sleep hold high", 16'(hi), 16'd40);
      reg_rd(`RCO_ADDR_STATUS, rv);
      check("status in sleep", 16'(rv), 16'h0003);
      @(posedge clk);
      sleep <= 1'h0;
      reg_wr(`RCO_ADDR_CONTROL, 8'h1B);
      // external sources: each edge of the source is one tick
      for (int s = 1; s < 3; s++) begin
         reg_wr(`RCO_ADDR_CONTROL, 8'h11);
         reg_wr(`RCO_ADDR_SOURCE, 8'(s));
         reg_rd(`RCO_ADDR_SOURCE, rv);
         check("source readback", 16'(rv), 16'(s));
         reg_wr(`RCO_ADDR_CONTROL, 8'h91);
         measure(hi, lo);
         check("ext high", 16'(hi), 16'(6 * s));
         check("ext period", 16'(hi + lo), 16'(12 * s));
      end
      reg_wr(`RCO_ADDR_CONTROL, 8'h11);
      reg_wr(`RCO_ADDR_SOURCE, 8'h03);
      reg_wr(`RCO_ADDR_CONTROL, 8'h91);
      count_hi(100, hi);
      check("absent source high", 16'(hi), 16'h0000);
      results();
   end
endmodule // testbench
